// ### hbcc_core.sv
// H-bridge drive, current chopping, decay sequencing and protection
//
// Operation
// - Each half-bridge output follows its own input, independently.
// - After trip, hold decay until the next chopping cycle starts.
// - Chopping cycle repeats at 50 kHz.
// - Trip when five times sensed level reaches scaled reference.
// - Five-bit scale code picks a fixed percentage, 0% up to 100%.
// - Trip ignored for 3.75 us after each drive start.
// - Clear input low resets logic, turns bridge off, ignores inputs.
// - Sleep low: bridge, pump, regulator and clocks off.
// - Qualified current limit latches bridge off and fault low.
// - Overcurrent acts on any transistor, apart from chopping.
// - Over-temperature turns bridge off, flags fault, self-recovers.
// - Supply low disables everything and resets logic until restored; over-temperature still drives the fault line low.
// - Fast decay reverses the bridge, then off near zero current.
// - Slow decay turns on both low sides for rest of cycle.
// - Decay select: low slow, high fast, open mixed.
// - Mixed decay: fast after trip, slow from 75% of cycle.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module hbcc_core
    import hbcc_pkg::*;
#(
    parameter int unsigned WAKE_CYC = HBCC_WAKE_CYC,
    parameter int unsigned OC_QUAL_CYC = HBCC_OC_QUAL_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bridge_input_a,
    input wire logic bridge_input_b,
    input wire logic [4:0] scale_code,
    input wire logic [1:0] decay_select,
    input wire logic [9:0] sense_node,
    input wire logic [9:0] reference_level,
    input wire logic winding_zero_current,
    input wire logic [3:0] current_limit,
    input wire logic over_temperature,
    input wire logic supply_low_lockout,
    input wire logic chip_clear_n,
    input wire logic low_power_request_n,
    input wire logic fault_flag_n_i,
    output logic fault_flag_n_o,
    output logic fault_flag_n_oe,
    output hbcc_half_t half_bridge_out_a,
    output hbcc_half_t half_bridge_out_b,
    output logic charge_pump_enable,
    output logic aux_regulator_enable
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [6:0] hbcc_scale_pct(input logic [4:0] code);
        logic [6:0] pct;
        pct = 7'h00;
        case (code)
            5'h00: pct = 7'h00;
            5'h01: pct = 7'h05;
            5'h02: pct = 7'h0A;
            5'h03: pct = 7'h0F;
            5'h04: pct = 7'h14;
            5'h05: pct = 7'h18;
            5'h06: pct = 7'h1D;
            5'h07: pct = 7'h22;
            5'h08: pct = 7'h26;
            5'h09: pct = 7'h2B;
            5'h0A: pct = 7'h2F;
            5'h0B: pct = 7'h33;
            5'h0C: pct = 7'h38;
            5'h0D: pct = 7'h3C;
            5'h0E: pct = 7'h3F;
            5'h0F: pct = 7'h43;
            5'h10: pct = 7'h47;
            5'h11: pct = 7'h4A;
            5'h12: pct = 7'h4D;
            5'h13: pct = 7'h50;
            5'h14: pct = 7'h53;
            5'h15: pct = 7'h56;
            5'h16: pct = 7'h58;
            5'h17: pct = 7'h5A;
            5'h18: pct = 7'h5C;
            5'h19: pct = 7'h5E;
            5'h1A: pct = 7'h60;
            5'h1B: pct = 7'h61;
            5'h1C: pct = 7'h62;
            5'h1D: pct = 7'h63;
            default: pct = 7'h64;
        endcase
        return pct;
    endfunction : hbcc_scale_pct

    function automatic hbcc_mode_t hbcc_decode_decay(input logic [1:0] lvl);
        hbcc_mode_t m;
        m = HBCC_MODE_MIXED;
        if (lvl == HBCC_DECAY_LOW) begin
            m = HBCC_MODE_SLOW;
        end else if (lvl == HBCC_DECAY_HIGH) begin
            m = HBCC_MODE_FAST;
        end
        return m;
    endfunction : hbcc_decode_decay

    // ****************************************************************
    // Submodules and combinational terms
    // ****************************************************************
    hbcc_core_t s;
    hbcc_core_t next_s;
    logic [9:0] phase_cnt;
    logic cycle_start;
    logic oc_latched;
    logic active_ok;
    logic run_ok;
    logic opposite;
    logic chop_run;
    logic trip;
    logic [18:0] sense_scaled;
    logic [16:0] ref_scaled;
    hbcc_mode_t mode;
    logic apb_done;
    logic pump_en_q;

    // Clear and supply loss both wipe internal state
    assign active_ok = chip_clear_n && low_power_request_n
        && !supply_low_lockout;
    assign run_ok = active_ok && s.wake_cnt >= 16'(WAKE_CYC)
        && !oc_latched && !over_temperature;
    assign opposite = bridge_input_a ^ bridge_input_b;
    assign chop_run = run_ok && opposite && s.reg_en;
    // Percent on both sides keeps the compare integer-exact
    assign sense_scaled = 19'(sense_node) * 19'(HBCC_SENSE_GAIN * 100);
    assign ref_scaled = 17'(reference_level) * 17'(hbcc_scale_pct(scale_code));
    assign trip = sense_scaled >= 19'(ref_scaled);
    assign mode = hbcc_decode_decay(decay_select);
    assign apb_done = psel && penable && s.pready;

    hbcc_chop_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(chop_run),
        .phase_cnt(phase_cnt),
        .cycle_start(cycle_start)
    );

    hbcc_oc_qualify #(
        .QUAL_CYC(OC_QUAL_CYC)
    ) u_ocq (
        .pclk(pclk),
        .presetn(presetn),
        .clear(!chip_clear_n || supply_low_lockout),
        .current_limit(current_limit),
        .oc_latched(oc_latched)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        // Sleep or supply low clears the wake timer; it counts again once both are released
        if (!low_power_request_n || supply_low_lockout) begin
            next_s.wake_cnt = 16'h0000;
        end else if (s.wake_cnt < 16'(WAKE_CYC)) begin
            next_s.wake_cnt = s.wake_cnt + 16'h0001;
        end
        if (!run_ok) begin
            next_s.st = HBCC_ST_OFF;
        end else if (!opposite || !s.reg_en) begin
            next_s.st = HBCC_ST_DRIVE;
        end else begin
            case (s.st)
                HBCC_ST_OFF: begin
                    next_s.st = HBCC_ST_DRIVE;
                end
                HBCC_ST_DRIVE: begin
                    // Blanking also fixes the least on-time per cycle
                    if (!cycle_start && trip
                        && phase_cnt >= 10'(HBCC_BLANK_CYC)) begin
                        next_s.trip_cnt = s.trip_cnt + 16'h0001;
                        next_s.st = (mode == HBCC_MODE_SLOW) ?
                            HBCC_ST_SLOW : HBCC_ST_FAST;
                    end
                end
                HBCC_ST_FAST, HBCC_ST_COAST: begin
                    if (cycle_start) begin
                        next_s.st = HBCC_ST_DRIVE;
                    end else if (mode == HBCC_MODE_MIXED
                        && phase_cnt >= 10'(HBCC_MIXED_CYC)) begin
                        next_s.st = HBCC_ST_SLOW;
                    end else if (winding_zero_current) begin
                        next_s.st = HBCC_ST_COAST;
                    end
                end
                HBCC_ST_SLOW: begin
                    if (cycle_start) begin
                        next_s.st = HBCC_ST_DRIVE;
                    end
                end
                default: begin
                    next_s.st = HBCC_ST_OFF;
                end
            endcase
        end
        if (!chip_clear_n || supply_low_lockout) begin
            next_s.trip_cnt = 16'h0000;
        end
        // Gate pattern follows the state being entered
        case (next_s.st)
            HBCC_ST_DRIVE: begin
                next_s.out_a = '{hs: bridge_input_a,
                    ls: !bridge_input_a};
                next_s.out_b = '{hs: bridge_input_b,
                    ls: !bridge_input_b};
            end
            HBCC_ST_FAST: begin
                next_s.out_a = '{hs: bridge_input_b,
                    ls: bridge_input_a};
                next_s.out_b = '{hs: bridge_input_a,
                    ls: bridge_input_b};
            end
            HBCC_ST_SLOW: begin
                next_s.out_a = '{hs: 1'b0, ls: 1'b1};
                next_s.out_b = '{hs: 1'b0, ls: 1'b1};
            end
            default: begin
                next_s.out_a = '0;
                next_s.out_b = '0;
            end
        endcase
        next_s.fault_oe = (oc_latched && chip_clear_n && !supply_low_lockout)
            || over_temperature;
        next_s.pump_en = low_power_request_n && !supply_low_lockout;
        next_s.aux_en = low_power_request_n && !supply_low_lockout;
        // APB: one wait state, answer registered
        next_s.pready = psel && penable && !s.pready;
        if (psel && penable && !s.pready) begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b0;
            case (paddr[7:0])
                HBCC_ADDR_CONFIG: begin
                    next_s.prdata[HBCC_CFG_REG_EN_BIT] = s.reg_en;
                end
                HBCC_ADDR_STATUS: begin
                    next_s.prdata[7:0] = {fault_flag_n_i, mode, s.st,
                        !low_power_request_n, over_temperature};
                    next_s.prdata[8] = oc_latched;
                    next_s.prdata[9] = supply_low_lockout;
                end
                HBCC_ADDR_TRIPS: begin
                    next_s.prdata[15:0] = s.trip_cnt;
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_done && pwrite && paddr[7:0] == HBCC_ADDR_CONFIG) begin
            next_s.reg_en = pwdata[HBCC_CFG_REG_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.reg_en <= HBCC_CFG_REG_EN_RST;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign half_bridge_out_a = s.out_a;
    assign half_bridge_out_b = s.out_b;
    assign fault_flag_n_o = 1'b0;
    assign fault_flag_n_oe = s.fault_oe;
    assign charge_pump_enable = s.pump_en;
    assign aux_regulator_enable = s.aux_en;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking hbcc_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    follow_inputs_a: assert property ((run_ok && !opposite) |=>
        s.out_a.hs == $past(bridge_input_a)
        && s.out_b.hs == $past(bridge_input_b)
        && s.out_a.ls != s.out_a.hs)
        else $error("equal inputs not passed to outputs");
    clear_off_a: assert property (!chip_clear_n |=>
        s.out_a == '0 && s.out_b == '0 && s.st == HBCC_ST_OFF)
        else $error("bridge not off under clear");
    sleep_off_a: assert property (!low_power_request_n |=>
        s.out_a == '0 && !charge_pump_enable && !aux_regulator_enable)
        else $error("sleep did not shut down");
    supply_low_lockout_reset_a: assert property (supply_low_lockout |=>
        s.st == HBCC_ST_OFF && s.trip_cnt == 16'h0000 && !pump_en_q)
        else $error("supply low did not reset");
    thermal_flag_a: assert property (over_temperature |=>
        fault_flag_n_oe && s.out_a == '0 && s.out_b == '0)
        else $error("over-temperature not handled");
    blank_hold_a: assert property ((s.st == HBCC_ST_DRIVE ##1
        (s.st == HBCC_ST_FAST || s.st == HBCC_ST_SLOW))
        |-> $past(phase_cnt) >= 10'(HBCC_BLANK_CYC))
        else $error("trip honoured inside blanking");
    decay_hold_a: assert property ((s.st != HBCC_ST_DRIVE
        && s.st != HBCC_ST_OFF && chop_run && !cycle_start)
        |=> s.st != HBCC_ST_DRIVE)
        else $error("decay left before cycle end");
    slow_gates_a: assert property (s.st == HBCC_ST_SLOW |->
        s.out_a == 2'h1 && s.out_b == 2'h1)
        else $error("slow decay gates wrong");
    mixed_switch_a: assert property ((chop_run && s.st == HBCC_ST_FAST
        && mode == HBCC_MODE_MIXED && !cycle_start
        && phase_cnt >= 10'(HBCC_MIXED_CYC)) |=> s.st == HBCC_ST_SLOW)
        else $error("mixed decay did not turn slow");

    assign pump_en_q = s.pump_en;

    slow_trip_c: cover property (s.st == HBCC_ST_DRIVE ##1
        s.st == HBCC_ST_SLOW);
    fast_coast_c: cover property (s.st == HBCC_ST_FAST ##1
        s.st == HBCC_ST_COAST);
    mixed_c: cover property (mode == HBCC_MODE_MIXED
        && s.st == HBCC_ST_FAST ##1 s.st == HBCC_ST_SLOW);
    oc_c: cover property ($rose(oc_latched));

endmodule : hbcc_core

// ### hbcc_pkg.sv
// Shared constants and carrier types for the H-bridge current chopper
package hbcc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned HBCC_CLK_KHZ = 40000;
    localparam int unsigned HBCC_PWM_KHZ = 50;
    localparam int unsigned HBCC_PWM_PERIOD_CYC = HBCC_CLK_KHZ / HBCC_PWM_KHZ;
    localparam int unsigned HBCC_BLANK_NS = 3750;
    localparam int unsigned HBCC_BLANK_CYC =
        (HBCC_BLANK_NS * HBCC_CLK_KHZ + 999999) / 1000000;
    localparam int unsigned HBCC_MIXED_PCT = 75;
    localparam int unsigned HBCC_MIXED_CYC =
        HBCC_PWM_PERIOD_CYC * HBCC_MIXED_PCT / 100;
    localparam int unsigned HBCC_WAKE_US = 1000;
    localparam int unsigned HBCC_WAKE_CYC =
        HBCC_WAKE_US * (HBCC_CLK_KHZ / 1000);
    localparam int unsigned HBCC_OC_QUAL_CYC = 120;
    localparam int unsigned HBCC_SENSE_GAIN = 5;

    // ****************************************************************
    // Decay select levels and register map
    // ****************************************************************
    localparam logic [1:0] HBCC_DECAY_LOW = 2'h0;
    localparam logic [1:0] HBCC_DECAY_HIGH = 2'h3;
    localparam logic [7:0] HBCC_ADDR_CONFIG = 8'h00;
    localparam logic [7:0] HBCC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] HBCC_ADDR_TRIPS = 8'h08;
    localparam int unsigned HBCC_CFG_REG_EN_BIT = 0;
    localparam logic HBCC_CFG_REG_EN_RST = 1'b1;

    typedef enum logic [1:0] {
        HBCC_MODE_SLOW,
        HBCC_MODE_FAST,
        HBCC_MODE_MIXED
    } hbcc_mode_t;

    typedef enum logic [2:0] {
        HBCC_ST_OFF,
        HBCC_ST_DRIVE,
        HBCC_ST_FAST,
        HBCC_ST_COAST,
        HBCC_ST_SLOW
    } hbcc_state_t;

    // Gate enables of one half-bridge
    typedef struct packed {
        logic hs;
        logic ls;
    } hbcc_half_t;

    typedef struct packed {
        hbcc_state_t st;
        hbcc_half_t out_a;
        hbcc_half_t out_b;
        logic fault_oe;
        logic pump_en;
        logic aux_en;
        logic [15:0] wake_cnt;
        logic reg_en;
        logic [15:0] trip_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } hbcc_core_t;

endpackage : hbcc_pkg

// ### hbcc_chop_timer.sv
// Fixed-period chopping cycle timer
`timescale 1ns/1ps
module hbcc_chop_timer
    import hbcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic [9:0] phase_cnt,
    output logic cycle_start
);

    typedef struct packed {
        logic [9:0] cnt;
        logic start;
    } hbcc_tmr_t;

    hbcc_tmr_t s;
    hbcc_tmr_t next_s;

    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        if (!run) begin
            // Clock effectively halted; next run opens a fresh cycle
            next_s.cnt = 10'h000;
        end else if (s.cnt == 10'(HBCC_PWM_PERIOD_CYC - 1)) begin
            next_s.cnt = 10'h000;
            next_s.start = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign phase_cnt = s.cnt;
    assign cycle_start = s.start;

    period_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run && s.cnt == 10'(HBCC_PWM_PERIOD_CYC - 1)) ##1 run
        |-> s.start && s.cnt == 10'h000)
        else $error("chop cycle did not restart at period end");

endmodule : hbcc_chop_timer

// ### hbcc_oc_qualify.sv
// Overcurrent qualification counter and shutdown latch
`timescale 1ns/1ps
module hbcc_oc_qualify
    import hbcc_pkg::*;
#(
    parameter int unsigned QUAL_CYC = HBCC_OC_QUAL_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic [3:0] current_limit,
    output logic oc_latched
);

    typedef struct packed {
        logic [15:0] cnt;
        logic latched;
    } hbcc_ocq_t;

    hbcc_ocq_t s;
    hbcc_ocq_t next_s;
    logic limit_any;

    // Any of the four transistors, high or low side alike
    assign limit_any = |current_limit;

    always_comb begin
        next_s = s;
        if (clear) begin
            // Reset or supply loss is the only way out of the latch
            next_s = '0;
        end else if (!limit_any) begin
            next_s.cnt = 16'h0000;
        end else if (s.cnt >= 16'(QUAL_CYC - 1)) begin
            next_s.latched = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign oc_latched = s.latched;

    qual_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!clear && !limit_any) |=> s.cnt == 16'h0000)
        else $error("qualification count did not restart");
    oc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s.latched && !clear) |=> s.latched)
        else $error("overcurrent latch released without clear");

endmodule : hbcc_oc_qualify

// ### hbcc_host_model.sv
// Host controller model driving bridge, scale, decay and control pins
`timescale 1ns/1ps
module hbcc_host_model (
    input wire logic pclk,
    output logic bridge_input_a,
    output logic bridge_input_b,
    output logic [4:0] scale_code,
    output logic [1:0] decay_select,
    output logic [9:0] sense_node,
    output logic [9:0] reference_level,
    output logic chip_clear_n,
    output logic low_power_request_n
);
    // Undriven pins read as their internal bias until the host takes over
    initial begin
        bridge_input_a = 1'b0;
        bridge_input_b = 1'b0;
        scale_code = 5'h00;
        sense_node = 10'h000;
        reference_level = 10'h000;
        chip_clear_n = 1'b0;
        low_power_request_n = 1'b0;
        decay_select = 2'h1;
    end

    // An external speed PWM is just a run of these calls
    task automatic pins(input logic a, input logic b);
        @(posedge pclk);
        bridge_input_a <= a;
        bridge_input_b <= b;
    endtask : pins

    task automatic analog(input logic [4:0] sc, input logic [1:0] dk,
        input logic [9:0] sn, input logic [9:0] rf);
        @(posedge pclk);
        scale_code <= sc;
        decay_select <= dk;
        sense_node <= sn;
        reference_level <= rf;
    endtask : analog

    // Both lines high for operation; caller waits out the wake time
    task automatic ctl(input logic clr_n, input logic slp_n);
        @(posedge pclk);
        chip_clear_n <= clr_n;
        low_power_request_n <= slp_n;
    endtask : ctl
endmodule : hbcc_host_model

// ### tb_hbcc_core.sv
// Self-checking testbench for the H-bridge current chopper core
`timescale 1ns/1ps
module tb_hbcc_core;
    import hbcc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, f_oe, f_o, pump, aux;
    logic wz = 1'b0;
    logic ot = 1'b0;
    logic sl = 1'b0;
    logic [3:0] cl = 4'h0;
    logic a, b, clr_n, slp_n;
    logic [4:0] sc;
    logic [1:0] dk;
    logic [9:0] sn, rf;
    hbcc_half_t ga, gb;
    int error_cnt = 0;
    int samples_checked = 0;
    // Code, sense level, trip expected against reference 1000
    logic [15:0] tbl [5] = '{{5'h00, 10'd100, 1'b1}, {5'h0A, 10'd100, 1'b1},
        {5'h0B, 10'd100, 1'b0}, {5'h1E, 10'd200, 1'b1},
        {5'h1F, 10'd199, 1'b0}};
    // Open-drain fault line with board pull-up
    wire logic pin = f_oe ? f_o : 1'b1;

    hbcc_host_model host (.pclk(pclk), .bridge_input_a(a),
        .bridge_input_b(b), .scale_code(sc), .decay_select(dk),
        .sense_node(sn), .reference_level(rf), .chip_clear_n(clr_n),
        .low_power_request_n(slp_n));
    // Short wake and qualification counts keep the run brief
    hbcc_core #(.WAKE_CYC(20), .OC_QUAL_CYC(4)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bridge_input_a(a), .bridge_input_b(b),
        .scale_code(sc), .decay_select(dk), .sense_node(sn),
        .reference_level(rf), .winding_zero_current(wz),
        .current_limit(cl), .over_temperature(ot),
        .supply_low_lockout(sl), .chip_clear_n(clr_n),
        .low_power_request_n(slp_n), .fault_flag_n_i(pin),
        .fault_flag_n_o(f_o), .fault_flag_n_oe(f_oe),
        .half_bridge_out_a(ga), .half_bridge_out_b(gb),
        .charge_pump_enable(pump), .aux_regulator_enable(aux));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        forever #12.5 pclk = ~pclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic gt(input logic [3:0] exp);
        chk("gates", {28'h0, ga, gb}, {28'h0, exp});
    endtask : gt

    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, ad};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Equal inputs park the chop timer, opposite inputs restart it
    task automatic chop;
        host.pins(1'b0, 1'b0);
        cyc(3);
        host.pins(1'b1, 1'b0);
    endtask : chop

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        cyc(20000);
        error_cnt++;
        tally_and_finish();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        cyc(4);
        presetn <= 1'b1;
        host.ctl(1'b1, 1'b1);
        cyc(30);
        apb(1'b0, HBCC_ADDR_CONFIG, 32'h0, q, e);
        chk("config", q, 32'h1);
        apb(1'b0, 8'h0C, 32'h0, q, e);
        chk("slverr", {31'h0, e}, 32'h1);
        chk("unmapped", q, 32'h0);
        apb(1'b0, HBCC_ADDR_STATUS, 32'h0, q, e);
        chk("status", q, 32'hC4);
        $display("test registers done");
        host.analog(5'h1F, HBCC_DECAY_LOW, 10'h3FF, 10'h001);
        for (int i = 0; i < 4; i++) begin
            host.pins(i[1], i[0]);
            cyc(3);
            gt({i[1], ~i[1], i[0], ~i[0]});
        end
        $display("test follow done");
        chop();
        cyc(100);
        gt(4'b1001);
        cyc(100);
        gt(4'b0101);
        apb(1'b0, HBCC_ADDR_TRIPS, 32'h0, q, e);
        chk("trips", q, 32'h1);
        cyc(660);
        gt(4'b1001);
        cyc(140);
        gt(4'b0101);
        host.analog(5'h1F, HBCC_DECAY_HIGH, 10'h3FF, 10'h001);
        chop();
        cyc(200);
        gt(4'b0110);
        wz <= 1'b1;
        cyc(3);
        gt(4'b0000);
        wz <= 1'b0;
        host.analog(5'h1F, 2'h2, 10'h3FF, 10'h001);
        chop();
        cyc(200);
        gt(4'b0110);
        cyc(450);
        gt(4'b0101);
        $display("test decay done");
        for (int i = 0; i < 5; i++) begin
            host.analog(tbl[i][15:11], HBCC_DECAY_LOW, tbl[i][10:1],
                10'd1000);
            chop();
            cyc(200);
            gt(tbl[i][0] ? 4'b0101 : 4'b1001);
        end
        $display("test scale done");
        host.analog(5'h1F, HBCC_DECAY_LOW, 10'h3FF, 10'h001);
        apb(1'b1, HBCC_ADDR_CONFIG, 32'h0, q, e);
        chop();
        cyc(200);
        gt(4'b1001);
        apb(1'b1, HBCC_ADDR_CONFIG, 32'h1, q, e);
        host.pins(1'b1, 1'b1);
        cl <= 4'h1;
        cyc(3);
        cl <= 4'h0;
        cyc(3);
        gt(4'b1010);
        cl <= 4'h8;
        cyc(6);
        cl <= 4'h0;
        cyc(20);
        gt(4'b0000);
        chk("fault", {31'h0, pin}, 32'h0);
        apb(1'b0, HBCC_ADDR_STATUS, 32'h0, q, e);
        chk("oc_status", {31'h0, q[8]}, 32'h1);
        host.ctl(1'b0, 1'b1);
        cyc(3);
        gt(4'b0000);
        host.ctl(1'b1, 1'b1);
        cyc(30);
        gt(4'b1010);
        chk("fault", {31'h0, pin}, 32'h1);
        ot <= 1'b1;
        cyc(3);
        gt(4'b0000);
        chk("fault", {31'h0, pin}, 32'h0);
        ot <= 1'b0;
        cyc(30);
        gt(4'b1010);
        sl <= 1'b1;
        cyc(3);
        gt(4'b0000);
        chk("pump", {31'h0, pump}, 32'h0);
        sl <= 1'b0;
        cyc(30);
        gt(4'b1010);
        host.ctl(1'b1, 1'b0);
        cyc(3);
        gt(4'b0000);
        chk("pump_aux", {30'h0, pump, aux}, 32'h0);
        host.ctl(1'b1, 1'b1);
        cyc(30);
        gt(4'b1010);
        $display("test protection done");
        tally_and_finish();
    end
endmodule : tb_hbcc_core
